// ===== verilog/pic_ctrl.v
// priority interrupt controller: one non-maskable and four maskable sources
// assumes the core drives instruction-boundary, entry-ack and return strobes on core_clk
`timescale 1ns/1ps
`default_nettype none
`include "pic_defines.vh"

// Functional notes
// - non-maskable request has top priority and pre-empts any maskable service routine
// - maskable routines never pre-empt each other; no nesting among them
// - pending maskable requests served by fixed priority, source 1 highest
// - each source maps to a fixed vector word pair in program space
// - accepting a request loads the program counter with that vector
// - global enable clear blocks maskable sources, non-maskable stays active
// - with global enable clear no source wakes the core from stop or wait
// - non-maskable request captured in flip-flop, cleared when its routine begins
// - level/edge select set gives level sensing on source 1, else falling edge
// - source 2 always edge sensitive; polarity bit set rising, clear falling
// - sources 3 and 4 always level sensitive with no edge option
// - edge latch set on active edge, cleared at routine start; extra edges lost
// - level requests not stored; requester holds low until sampled
// - lines sampled at each instruction end; request replaces next instruction
// - per-event flags let software find which ORed event caused a request
// - option register write-only at 0C8h, reset 00h, no single-bit operations
// - option bit 6 level/edge, bit 5 polarity, bit 4 global enable
// - entry swaps flag set, pushes program counter, inhibits maskable lines
module pic_ctrl (
  input wire core_clk,
  input wire arst_n,
  // interrupt pins, asynchronous to core_clk, active low except src2_pin, whose polarity is selectable
  input wire nmi_n,
  input wire src1_n,
  input wire src2_pin,
  input wire src3_n,
  input wire src4_n,
  // per-event detail ORed onto sources, passed through for polling
  input wire [7:0] src_event_flags,
  output reg [7:0] event_flags_r,
  // data-space write port of the core
  input wire wr_en,
  input wire [7:0] wr_addr,
  input wire [7:0] wr_data,
  // core handshake
  input wire instr_end,
  input wire entry_ack,
  input wire return_from_interrupt,
  input wire core_sleeping,
  output wire irq_take,
  output reg [11:0] vector_addr_r,
  output reg [1:0] flag_set_sel_r,
  output reg wake_r,
  output reg level_edge_select_r,
  output reg edge_polarity_select_r,
  output reg global_interrupt_enable_r
);

  // ==========================================================
  // input synchronisers
  reg [4:0] sync1_r;
  reg [4:0] sync2_r;
  reg [4:0] prev_r;
  reg [2:0] arm_r;
  wire [4:0] pins = {src4_n, src3_n, src2_pin, src1_n, nmi_n};

  // reset values of the pipeline need not match the idle pin levels,
  // so edges are ignored until three real samples have passed
  always @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      arm_r <= `PIC_ARM_RESET;
    end else begin
      arm_r <= {arm_r[1:0], 1'b1};
    end
  end

  always @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      sync1_r <= 5'h1F;
      sync2_r <= 5'h1F;
      prev_r <= 5'h1F;
    end else begin
      sync1_r <= pins;
      sync2_r <= sync1_r;
      prev_r <= sync2_r;
    end
  end

  wire fall0 = arm_r[2] & prev_r[0] & ~sync2_r[0];
  wire fall1 = arm_r[2] & prev_r[1] & ~sync2_r[1];
  wire rise2 = arm_r[2] & ~prev_r[2] & sync2_r[2];
  wire fall2 = arm_r[2] & prev_r[2] & ~sync2_r[2];
  wire edge2 = edge_polarity_select_r ? rise2 : fall2;

  // ==========================================================
  // option register: write-only, whole-byte writes
  always @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      level_edge_select_r <= `PIC_OPT_BIT_RESET;
      edge_polarity_select_r <= `PIC_OPT_BIT_RESET;
      global_interrupt_enable_r <= `PIC_OPT_BIT_RESET;
    end else if (wr_en && wr_addr == `PIC_IOR_ADDR) begin
      // only full byte stores exist, so no read-modify-write path is needed
      level_edge_select_r <= wr_data[`PIC_BIT_LES];
      edge_polarity_select_r <= wr_data[`PIC_BIT_ESB];
      global_interrupt_enable_r <= wr_data[`PIC_BIT_GEN];
    end
  end

  // ==========================================================
  // core level tracking and service selection
  reg [1:0] level_r;
  reg [1:0] saved_level_r;
  reg nmi_latch_r;
  reg src1_latch_r;
  reg src2_latch_r;
  reg [4:0] taken_r;

  wire req1 = level_edge_select_r ? ~sync2_r[1] : src1_latch_r;
  wire req3 = ~sync2_r[3];
  wire req4 = ~sync2_r[4];
  wire mask_ok = global_interrupt_enable_r && level_r == `PIC_LVL_NORMAL;
  wire nmi_ok = nmi_latch_r && level_r != `PIC_LVL_NMI;

  reg [4:0] pick;
  always @* begin
    pick = 5'h00;
    if (nmi_ok) begin
      pick = 5'h01;
    end else if (mask_ok) begin
      if (req1) begin
        pick = 5'h02;
      end else if (src2_latch_r) begin
        pick = 5'h04;
      end else if (req3) begin
        pick = 5'h08;
      end else if (req4) begin
        pick = 5'h10;
      end
    end
  end

  // request replaces next instruction; combinational handshake
  assign irq_take = instr_end && (pick != 5'h00);

  reg [11:0] vec_nxt;
  always @* begin
    case (pick)
      5'h01: vec_nxt = `PIC_VEC_SRC0;
      5'h02: vec_nxt = `PIC_VEC_SRC1;
      5'h04: vec_nxt = `PIC_VEC_SRC2;
      5'h08: vec_nxt = `PIC_VEC_SRC3;
      5'h10: vec_nxt = `PIC_VEC_SRC4;
      default: vec_nxt = `PIC_VEC_NONE;
    endcase
  end

  always @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      // out of reset the core runs in non-maskable mode until its first return
      level_r <= `PIC_LVL_NMI;
      saved_level_r <= `PIC_LVL_NORMAL;
      taken_r <= 5'h00;
      vector_addr_r <= `PIC_VEC_NONE;
      flag_set_sel_r <= `PIC_LVL_NMI;
    end else if (irq_take) begin
      vector_addr_r <= vec_nxt;
      taken_r <= pick;
      // one saved level suffices: only nmi can nest over a maskable routine
      saved_level_r <= level_r;
      level_r <= pick[0] ? `PIC_LVL_NMI : `PIC_LVL_MASK;
      flag_set_sel_r <= pick[0] ? `PIC_LVL_NMI : `PIC_LVL_MASK;
    end else if (return_from_interrupt) begin
      level_r <= saved_level_r;
      flag_set_sel_r <= saved_level_r;
      saved_level_r <= `PIC_LVL_NORMAL;
    end
  end

  // ==========================================================
  // request latches: set wins over clear
  wire clr0 = entry_ack && taken_r[0];
  wire clr1 = entry_ack && taken_r[1];
  wire clr2 = entry_ack && taken_r[2];

  always @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      nmi_latch_r <= 1'b0;
      src1_latch_r <= 1'b0;
      src2_latch_r <= 1'b0;
    end else begin
      nmi_latch_r <= fall0 | (nmi_latch_r & ~clr0);
      // a second edge only re-sets an already set latch, so it is lost
      src1_latch_r <= (fall1 & ~level_edge_select_r) | (src1_latch_r & ~clr1);
      src2_latch_r <= edge2 | (src2_latch_r & ~clr2);
    end
  end

  // ==========================================================
  // wake-up and event flags
  wire any_req = nmi_latch_r | req1 | src2_latch_r | req3 | req4;

  always @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      wake_r <= 1'b0;
      event_flags_r <= 8'h00;
    end else begin
      wake_r <= core_sleeping && global_interrupt_enable_r && any_req;
      event_flags_r <= src_event_flags;
    end
  end

endmodule // pic_ctrl
`default_nettype wire

// ===== verilog/pic_defines.vh
// constants for the priority interrupt controller
// assumes inclusion by bare name from design files only
`ifndef PIC_DEFINES_VH
`define PIC_DEFINES_VH
// option register address and layout
`define PIC_IOR_ADDR 8'hC8
`define PIC_IOR_RESET 8'h00
`define PIC_OPT_BIT_RESET 1'b0
// edge detectors stay blind until the pin pipeline holds real samples
`define PIC_ARM_RESET 3'h0
`define PIC_BIT_LES 6
`define PIC_BIT_ESB 5
`define PIC_BIT_GEN 4
// vector addresses (first word of each pair)
`define PIC_VEC_SRC0 12'hFFC
`define PIC_VEC_SRC1 12'hFF6
`define PIC_VEC_SRC2 12'hFF4
`define PIC_VEC_SRC3 12'hFF2
`define PIC_VEC_SRC4 12'hFF0
`define PIC_VEC_NONE 12'h000
// level of the core
`define PIC_LVL_NORMAL 2'h0
`define PIC_LVL_MASK 2'h1
`define PIC_LVL_NMI 2'h2
`endif

// ===== sim/pic_ctrl_checker.sv
// assertions on the interrupt controller ports
// assumes one core_clk domain, bound onto pic_ctrl
`timescale 1ns/1ps
`default_nettype none
module pic_chk (input wire logic core_clk, arst_n, wr_en, instr_end, irq_take, wake_r,
  input wire logic level_edge_select_r, edge_polarity_select_r, global_interrupt_enable_r,
  input wire logic [7:0] wr_addr, wr_data, src_event_flags, event_flags_r,
  input wire logic [11:0] vector_addr_r, input wire logic [1:0] flag_set_sel_r);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!arst_n);
  wire gen = global_interrupt_enable_r;
  wire opt_wr = wr_en && wr_addr == 8'hC8;
  wire [2:0] opt_bits = wr_data[6:4];
  wire vec0 = vector_addr_r == 12'hFFC;
  // ====
  // option, sampling, priority, wake and event flag checks
  property p_opt; opt_wr |=> {level_edge_select_r, edge_polarity_select_r, gen}
    == $past(opt_bits); endproperty
  a_opt: assert property (p_opt) else $error("option bits");
  property p_hold; !opt_wr |=> $stable(gen); endproperty
  a_hold: assert property (p_hold) else $error("enable moved");
  property p_end; irq_take |-> instr_end; endproperty
  a_end: assert property (p_end) else $error("take off boundary");
  property p_vec; irq_take |=> vector_addr_r inside
    {12'hFFC, 12'hFF6, 12'hFF4, 12'hFF2, 12'hFF0}; endproperty
  a_vec: assert property (p_vec) else $error("bad vector");
  property p_nest; irq_take && flag_set_sel_r != 2'h0 |=> vec0; endproperty
  a_nest: assert property (p_nest) else $error("maskable nested");
  property p_gen; irq_take && !gen |=> vec0; endproperty
  a_gen: assert property (p_gen) else $error("masked source taken");
  property p_lvl; irq_take |=> flag_set_sel_r == (vec0 ? 2'h2 : 2'h1); endproperty
  a_lvl: assert property (p_lvl) else $error("flag set");
  property p_wake; !gen |=> !wake_r; endproperty
  a_wake: assert property (p_wake) else $error("wake while disabled");
  property p_evt; 1 |=> event_flags_r == $past(src_event_flags); endproperty
  a_evt: assert property (p_evt) else $error("event flags");
  c_nmi: cover property (irq_take ##1 vec0);
  c_wake: cover property (wake_r);
  c_opt: cover property (opt_wr);
endmodule // pic_chk
bind pic_ctrl pic_chk pic_chk_inst (.*);
`default_nettype wire

// ===== sim/pic_core_model.sv
// core side: boundaries, entry strobe, automatic return
// assumes irq_take is combinational from instr_end
`timescale 1ns/1ps
`default_nettype none
module pic_core_model (input wire logic core_clk, arst_n, irq_take,
  input wire logic [1:0] flag_set_sel_r,
  output logic instr_end, entry_ack, return_from_interrupt);
  logic [3:0] cnt_r;
  // ====
  // routine length fixed, long enough for an nmi to nest inside
  always @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      {instr_end, entry_ack, return_from_interrupt, cnt_r} <= '0;
    end else begin
      instr_end <= !instr_end && !irq_take;
      entry_ack <= irq_take;
      return_from_interrupt <= cnt_r == 4'hE && !irq_take;
      cnt_r <= (irq_take || return_from_interrupt || flag_set_sel_r == 2'h0) ? '0 : cnt_r + 1'b1;
    end
  end
endmodule // pic_core_model
`default_nettype wire

// ===== sim/tb_pic_ctrl.sv
// self-checking bench, vectors scored through a queue
// assumes pic_core_model stands in for the core
`timescale 1ns/1ps
`default_nettype none
module tb_pic_ctrl;
  logic core_clk = 0, arst_n = 0, nmi_n = 1, src1_n = 1, src2_pin = 0, src3_n = 1, src4_n = 1;
  logic wr_en = 0, core_sleeping = 0, instr_end, entry_ack, return_from_interrupt, irq_take;
  logic wake_r, level_edge_select_r, edge_polarity_select_r, global_interrupt_enable_r, taken_r;
  logic [7:0] wr_addr = 0, wr_data = 0, src_event_flags = 0, event_flags_r;
  logic [11:0] vector_addr_r, exp_q[$];
  logic [1:0] flag_set_sel_r;
  int miscompares = 0, n_checks = 0;
  pic_ctrl pic_ctrl_inst (.*);
  pic_core_model pic_core_model_inst (.*);
  initial forever #20 core_clk = !core_clk;
  task automatic chk(input logic [11:0] got, exp);
    n_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk);
  endtask
  task automatic wr_opt(input logic [7:0] a, d);
    wr_en <= 1;
    {wr_addr, wr_data} <= {a, d};
    cyc(1);
    wr_en <= 0;
    cyc(1);
  endtask
  task automatic stop_test;
    $display("checks %0d mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // ====
  // monitor: each take is scored; level requesters let go once served
  always @(posedge core_clk) begin
    src_event_flags <= 8'($urandom);
    taken_r <= irq_take;
    if (taken_r) begin
      chk(vector_addr_r, exp_q.size() ? exp_q.pop_front() : 'x);
      if (vector_addr_r === 12'hFF6) src1_n <= 1;
      if (vector_addr_r === 12'hFF2) src3_n <= 1;
      if (vector_addr_r === 12'hFF0) src4_n <= 1;
    end
  end
  initial begin
    void'($urandom(32'hea56));
    cyc(6);
    arst_n <= 1;
    cyc(2);
    chk({flag_set_sel_r, level_edge_select_r, edge_polarity_select_r,
      global_interrupt_enable_r}, 12'h010);
    cyc(30);
    wr_opt(8'hC9, 8'($urandom));
    wr_opt(8'hC8, 8'h30);
    exp_q = {exp_q, 12'hFF6, 12'hFF4, 12'hFF2, 12'hFF0};
    {src1_n, src2_pin} <= 2'b01;
    cyc(1);
    {src3_n, src4_n} <= 2'b00;
    cyc(9);
    src2_pin <= 0;
    cyc(2);
    src2_pin <= 1;
    cyc(100);
    exp_q = {exp_q, 12'hFF2, 12'hFFC};
    src3_n <= 0;
    cyc(8);
    nmi_n <= 0;
    cyc(4);
    nmi_n <= 1;
    cyc(60);
    wr_opt(8'hC8, 8'h40);
    exp_q = {exp_q, 12'hFFC};
    {src1_n, core_sleeping, nmi_n} <= 3'b010;
    cyc(4);
    nmi_n <= 1;
    chk({11'h000, wake_r}, 12'h000);
    cyc(60);
    exp_q = {exp_q, 12'hFF6};
    wr_opt(8'hC8, 8'h50);
    cyc(1);
    chk({11'h000, wake_r}, 12'h001);
    cyc(39);
    if (exp_q.size()) miscompares++;
    stop_test();
  end
  initial begin
    #100us;
    miscompares++;
    stop_test();
  end
endmodule // tb_pic_ctrl
`default_nettype wire
